// ==== logic/cpuex_regs.svh ====
// Constants for the exception entry sequencer
`ifndef CPUEX_REGS_SVH
`define CPUEX_REGS_SVH
`define CPUEX_RESET_VEC_HI 16'hfffe
`define CPUEX_RESET_VEC_LO 16'hffff
`define CPUEX_RESET_SEQ_CYCLES 6
`define CPUEX_STACK_BYTES 5
`define CPUEX_QUEUE_BYTES 3
`define CPUEX_PAGE2_PREFIX 8'h9e
`define CPUEX_OP_NEGATE_OFS8 8'h60
`define CPUEX_NEGATE_OFS8_BYTES 3
`define CPUEX_NEGATE_OFS8_CYCLES 6
`define CPUEX_MASK_BIT 3
`endif

// ==== logic/cpuex_pkg.sv ====
// Types for the exception entry sequencer
package cpuex_pkg;
    typedef enum logic [3:0] {
        CPUEX_ST_RESET,
        CPUEX_ST_RVEC_HI,
        CPUEX_ST_RVEC_LO,
        CPUEX_ST_RIDLE,
        CPUEX_ST_RUN,
        CPUEX_ST_STACK,
        CPUEX_ST_VEC_HI,
        CPUEX_ST_VEC_LO,
        CPUEX_ST_IDLE,
        CPUEX_ST_FILL
    } cpuex_state_t;
    typedef enum logic [1:0] {
        CPUEX_MODE_NONE,
        CPUEX_MODE_SP8,
        CPUEX_MODE_SP16
    } cpuex_sp_mode_t;
endpackage

// ==== logic/cpuex_prio.sv ====
// Pending interrupt priority encoder, vector address out of a register
`timescale 1ns/1ps
module cpuex_prio #(
    parameter int NUM_IRQ = 8
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic [NUM_IRQ-1:0] pending_i,
    input wire logic capture_i,
    input wire logic [15:0] vector_base_i,
    output logic [15:0] vector_addr_o,
    output logic any_o
);
    logic [15:0] vec_q;

    // Lowest index is the highest priority; two bytes per vector
    function automatic logic [15:0] pick(input logic [NUM_IRQ-1:0] p, input logic [15:0] b);
        logic [15:0] r;
        r = b;
        for (int i = NUM_IRQ - 1; i >= 0; i--) begin
            if (p[i]) begin
                r = b - 16'(2 * (i + 1));
            end
        end
        return r;
    endfunction

    assign any_o = |pending_i;

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vec_q <= 16'h0000;
        end else if (capture_i) begin
            vec_q <= pick(pending_i, vector_base_i);
        end
    end

    assign vector_addr_o = vec_q;
endmodule

// ==== logic/cpuex_seq.sv ====
// Reset and interrupt entry sequencer with page-two decode
`timescale 1ns/1ps
`include "cpuex_regs.svh"
//
// Notes on behaviour
// - Any reset source aborts current activity, the pin only after its two-flop synchroniser; no instruction boundary wait.
// - Reset ends once internal source check is done and pin released.
// - Six-cycle start: read 0xFFFE, 0xFFFF, idle, fill three queue bytes.
// - Interrupts are taken only at an instruction boundary; saved PC is next.
// - Vector comes from highest-priority pending interrupt when entry begins.
// - Stack order: PC low, PC high, index low, accumulator, condition codes.
// - Mask flag is set right after condition codes are stacked.
// - Vector high byte is read first, then the low byte.
// - Exactly one idle bus cycle follows the vector reads.
// - Three consecutive program bytes from the vector fill the queue.
// - Index high byte is never stacked on entry.
// - Software trap uses the same entry, ignores the mask, is synchronous.
// - A cleared mask in the service routine lets further interrupts nest.
// - Leading byte 9E selects the second-page opcode table.
// - Second page offers 8-bit and 16-bit stack-pointer offset addressing.
// - Second-page negate with 8-bit stack offset is 3 bytes, 6 cycles.
module cpuex_seq
    import cpuex_pkg::*;
#(
    parameter int NUM_IRQ = 8,
    parameter logic [15:0] IRQ_VECTOR_BASE = 16'hfffc
) (
    input wire logic ref_clk_i,
    input wire logic reset_i,
    input wire logic por_i,
    input wire logic watchdog_reset_i,
    input wire logic reset_pin_n_i,
    input wire logic source_check_done_i,
    input wire logic [NUM_IRQ-1:0] irq_i,
    input wire logic instr_boundary_i,
    input wire logic trap_exec_i,
    input wire logic mask_clear_i,
    input wire logic [15:0] pc_i,
    input wire logic [7:0] index_low_i,
    input wire logic [7:0] acc_i,
    input wire logic [7:0] condition_code_register_i,
    input wire logic [15:0] sp_i,
    input wire logic [7:0] opcode_i,
    input wire logic opcode_valid_i,
    input wire logic [15:0] offset_i,
    input wire logic [7:0] rdata_i,
    output logic bus_req_o,
    output logic bus_we_o,
    output logic [15:0] bus_addr_o,
    output logic [7:0] bus_wdata_o,
    output logic [15:0] pc_load_o,
    output logic pc_load_valid_o,
    output logic mask_o,
    output logic running_o,
    output logic page2_o,
    output logic [1:0] sp_mode_o,
    output logic [15:0] sp_operand_addr_o,
    output logic [3:0] instr_bytes_o,
    output logic [3:0] instr_cycles_o
);
    cpuex_state_t state_q;
    logic [2:0] cnt_q;
    logic [15:0] sp_q;
    logic [15:0] vec_q;
    logic [7:0] vec_hi_q;
    logic mask_q;
    logic page2_q;
    logic pin_s1_q;
    logic pin_s2_q;
    logic int_reset;
    logic reset_done;
    logic take_irq;
    logic take_trap;
    logic entry;
    logic [15:0] irq_vec;
    logic irq_any;
    cpuex_sp_mode_t mode_d;

    // Pin is asynchronous to the core clock
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            pin_s1_q <= 1'b0;
            pin_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= reset_pin_n_i;
            pin_s2_q <= pin_s1_q;
        end
    end

    assign int_reset = por_i | watchdog_reset_i | ~pin_s2_q;
    assign reset_done = source_check_done_i & pin_s2_q;
    assign take_irq = (state_q == CPUEX_ST_RUN) && instr_boundary_i && irq_any
        && !mask_q;
    assign take_trap = (state_q == CPUEX_ST_RUN) && trap_exec_i;
    assign entry = take_irq | take_trap;

    cpuex_prio #(
        .NUM_IRQ(NUM_IRQ)
    ) u_prio (
        .ref_clk_i(ref_clk_i),
        .reset_i(reset_i),
        .pending_i(take_trap ? '0 : irq_i),
        .capture_i(entry),
        .vector_base_i(IRQ_VECTOR_BASE),
        .vector_addr_o(irq_vec),
        .any_o(irq_any)
    );

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            state_q <= CPUEX_ST_RESET;
            cnt_q <= 3'h0;
        end else if (int_reset) begin
            state_q <= CPUEX_ST_RESET;
            cnt_q <= 3'h0;
        end else begin
            case (state_q)
                CPUEX_ST_RESET: begin
                    if (reset_done) begin
                        state_q <= CPUEX_ST_RVEC_HI;
                    end
                end
                CPUEX_ST_RVEC_HI: state_q <= CPUEX_ST_RVEC_LO;
                CPUEX_ST_RVEC_LO: state_q <= CPUEX_ST_RIDLE;
                CPUEX_ST_RIDLE: begin
                    state_q <= CPUEX_ST_FILL;
                    cnt_q <= 3'h0;
                end
                CPUEX_ST_RUN: begin
                    if (entry) begin
                        state_q <= CPUEX_ST_STACK;
                        cnt_q <= 3'h0;
                    end
                end
                CPUEX_ST_STACK: begin
                    if (cnt_q == 3'(`CPUEX_STACK_BYTES - 1)) begin
                        state_q <= CPUEX_ST_VEC_HI;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                CPUEX_ST_VEC_HI: state_q <= CPUEX_ST_VEC_LO;
                CPUEX_ST_VEC_LO: state_q <= CPUEX_ST_IDLE;
                CPUEX_ST_IDLE: begin
                    state_q <= CPUEX_ST_FILL;
                    cnt_q <= 3'h0;
                end
                CPUEX_ST_FILL: begin
                    if (cnt_q == 3'(`CPUEX_QUEUE_BYTES - 1)) begin
                        state_q <= CPUEX_ST_RUN;
                    end else begin
                        cnt_q <= cnt_q + 3'h1;
                    end
                end
                default: state_q <= CPUEX_ST_RESET;
            endcase
        end
    end

    // Stack pointer snapshot, decremented per push
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            sp_q <= 16'h0000;
        end else if (entry) begin
            sp_q <= sp_i;
        end else if (state_q == CPUEX_ST_STACK) begin
            sp_q <= sp_q - 16'h0001;
        end
    end

    // Vector bytes; high byte always lands first
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            vec_hi_q <= 8'h00;
            vec_q <= 16'h0000;
        end else begin
            if (state_q == CPUEX_ST_RVEC_HI || state_q == CPUEX_ST_VEC_HI) begin
                vec_hi_q <= rdata_i;
            end
            if (state_q == CPUEX_ST_RVEC_LO || state_q == CPUEX_ST_VEC_LO) begin
                vec_q <= {vec_hi_q, rdata_i};
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            mask_q <= 1'b1;
        end else if (int_reset) begin
            mask_q <= 1'b1;
        end else if (state_q == CPUEX_ST_STACK && cnt_q == 3'(`CPUEX_STACK_BYTES - 1)) begin
            mask_q <= 1'b1;
        end else if (mask_clear_i && state_q == CPUEX_ST_RUN) begin
            mask_q <= 1'b0;
        end
    end

    // Stacked bytes; index high is deliberately absent
    function automatic logic [7:0] stack_byte(input logic [2:0] idx);
        case (idx)
            3'h0: stack_byte = pc_i[7:0];
            3'h1: stack_byte = pc_i[15:8];
            3'h2: stack_byte = index_low_i;
            3'h3: stack_byte = acc_i;
            default: stack_byte = condition_code_register_i;
        endcase
    endfunction

    always_comb begin
        bus_req_o = 1'b0;
        bus_we_o = 1'b0;
        bus_addr_o = 16'h0000;
        bus_wdata_o = 8'h00;
        case (state_q)
            CPUEX_ST_RVEC_HI: begin
                bus_req_o = 1'b1;
                bus_addr_o = `CPUEX_RESET_VEC_HI;
            end
            CPUEX_ST_RVEC_LO: begin
                bus_req_o = 1'b1;
                bus_addr_o = `CPUEX_RESET_VEC_LO;
            end
            CPUEX_ST_STACK: begin
                bus_req_o = 1'b1;
                bus_we_o = 1'b1;
                bus_addr_o = sp_q;
                bus_wdata_o = stack_byte(cnt_q);
            end
            CPUEX_ST_VEC_HI: begin
                bus_req_o = 1'b1;
                bus_addr_o = irq_vec;
            end
            CPUEX_ST_VEC_LO: begin
                bus_req_o = 1'b1;
                bus_addr_o = irq_vec + 16'h0001;
            end
            CPUEX_ST_FILL: begin
                bus_req_o = 1'b1;
                bus_addr_o = vec_q + 16'(cnt_q);
            end
            default: begin
                bus_req_o = 1'b0;
            end
        endcase
    end

    assign pc_load_o = vec_q;
    assign pc_load_valid_o = (state_q == CPUEX_ST_FILL)
        && (cnt_q == 3'(`CPUEX_QUEUE_BYTES - 1));
    assign mask_o = mask_q;
    assign running_o = (state_q == CPUEX_ST_RUN);

    // Page-two decode: prefix byte latches until the next opcode byte
    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            page2_q <= 1'b0;
        end else if (int_reset) begin
            page2_q <= 1'b0;
        end else if (opcode_valid_i) begin
            page2_q <= !page2_q && (opcode_i == `CPUEX_PAGE2_PREFIX);
        end
    end

    always_comb begin
        mode_d = CPUEX_MODE_NONE;
        if (page2_q) begin
            if (opcode_i[7:4] == 4'h6 || opcode_i[7:4] == 4'he
                || opcode_i[7:4] == 4'hf) begin
                mode_d = CPUEX_MODE_SP8;
            end else if (opcode_i[7:4] == 4'hd) begin
                mode_d = CPUEX_MODE_SP16;
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge reset_i) begin
        if (reset_i) begin
            page2_o <= 1'b0;
            sp_mode_o <= 2'h0;
            sp_operand_addr_o <= 16'h0000;
            instr_bytes_o <= 4'h0;
            instr_cycles_o <= 4'h0;
        end else if (opcode_valid_i) begin
            page2_o <= page2_q;
            sp_mode_o <= mode_d;
            if (mode_d == CPUEX_MODE_SP8) begin
                sp_operand_addr_o <= sp_i + {8'h00, offset_i[7:0]};
            end else begin
                sp_operand_addr_o <= sp_i + offset_i;
            end
            if (page2_q && opcode_i == `CPUEX_OP_NEGATE_OFS8) begin
                instr_bytes_o <= 4'(`CPUEX_NEGATE_OFS8_BYTES);
                instr_cycles_o <= 4'(`CPUEX_NEGATE_OFS8_CYCLES);
            end else begin
                instr_bytes_o <= 4'h0;
                instr_cycles_o <= 4'h0;
            end
        end
    end

    sequence reset_fetch_s;
        (state_q == CPUEX_ST_RVEC_HI && bus_addr_o == 16'hfffe)
            ##1 (bus_addr_o == 16'hffff) ##1 !bus_req_o ##1 bus_req_o [*3];
    endsequence
    sequence stack_s;
        bus_we_o && bus_wdata_o == pc_i[7:0];
    endsequence

    reset_seq_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        $rose(state_q == CPUEX_ST_RVEC_HI) |-> reset_fetch_s ##1 running_o)
        else $error("reset start sequence wrong");
    reset_abort_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        int_reset |=> state_q == CPUEX_ST_RESET && !bus_req_o)
        else $error("reset did not abort");
    reset_wait_a: assert property (@(posedge ref_clk_i) disable iff (reset_i)
        state_q == CPUEX_ST_RESET && !reset_done |=> !bus_req_o)
        else $error("left reset too early");
    entry_start_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        take_irq |-> instr_boundary_i ##1 stack_s)
        else $error("entry not at boundary");
    mask_set_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        state_q == CPUEX_ST_STACK && cnt_q == 3'h4 |=> mask_o)
        else $error("mask not set after stacking");
    stack_len_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        entry |=> bus_we_o [*5] ##1 !bus_we_o [*6])
        else $error("stack length wrong");
    idle_gap_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        state_q == CPUEX_ST_VEC_LO |=> !bus_req_o ##1 bus_addr_o == vec_q)
        else $error("idle cycle missing");
    trap_mask_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        running_o && trap_exec_i |=> state_q == CPUEX_ST_STACK)
        else $error("trap not taken");
    page2_a: assert property (@(posedge ref_clk_i) disable iff (reset_i || int_reset)
        opcode_valid_i && page2_q && opcode_i == 8'h60 |=> instr_cycles_o == 4'h6
            && instr_bytes_o == 4'h3 && sp_mode_o == 2'h1)
        else $error("negate decode wrong");
endmodule

// ==== bench/cpuex_mem_model.sv ====
// Zero-wait memory standing behind the sequencer's bus
`timescale 1ns/1ps
module cpuex_mem_model (
    input wire logic ref_clk_i,
    input wire logic bus_req_i,
    input wire logic bus_we_i,
    input wire logic [15:0] bus_addr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] last_q = 8'h00;
    function automatic logic [7:0] byte_at(input logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    // Unread bus shows the inverse of the previous cycle's value, so the last read byte reappears every second cycle
    assign rdata_o = (bus_req_i && !bus_we_i) ? byte_at(bus_addr_i) : ~last_q;
    always @(posedge ref_clk_i) begin
        last_q <= rdata_o;
    end
endmodule

// ==== bench/cpuex_seq_tb_top.sv ====
// Self-checking bench for the exception entry sequencer
`timescale 1ns/1ps
module cpuex_seq_tb_top;
    typedef struct packed {logic [7:0] irq; logic trap; logic [15:0] vec;} cpuex_row_t;
    logic clk = 1'b0;
    logic rst, por, wdog, pin_n, chk_done, bnd, trap, mclr, opv;
    logic [7:0] irq, x, a, cond_code, opc, rdata, wdata;
    logic [15:0] pc, sp, offs, addr, pload, spaddr;
    logic req, we, pvld, mask, run, page2;
    logic [1:0] mode;
    logic [3:0] nbytes, ncyc;
    int errors = 0;
    int check_count = 0;
    cpuex_row_t rows[5] = '{'{8'h01, 1'b0, 16'hfffa}, '{8'h06, 1'b0, 16'hfff8},
        '{8'hc8, 1'b0, 16'hfff4}, '{8'h80, 1'b0, 16'hffec}, '{8'h00, 1'b1, 16'hfffc}};
    always #2.5 clk = ~clk;
    cpuex_seq u_dut (.ref_clk_i(clk), .reset_i(rst), .por_i(por), .watchdog_reset_i(wdog),
        .reset_pin_n_i(pin_n), .source_check_done_i(chk_done), .irq_i(irq),
        .instr_boundary_i(bnd), .trap_exec_i(trap), .mask_clear_i(mclr), .pc_i(pc),
        .index_low_i(x), .acc_i(a), .condition_code_register_i(cond_code), .sp_i(sp),
        .opcode_i(opc), .opcode_valid_i(opv), .offset_i(offs), .rdata_i(rdata),
        .bus_req_o(req),
        .bus_we_o(we), .bus_addr_o(addr), .bus_wdata_o(wdata), .pc_load_o(pload),
        .pc_load_valid_o(pvld), .mask_o(mask), .running_o(run), .page2_o(page2),
        .sp_mode_o(mode), .sp_operand_addr_o(spaddr), .instr_bytes_o(nbytes),
        .instr_cycles_o(ncyc));
    cpuex_mem_model u_mem (.ref_clk_i(clk), .bus_req_i(req), .bus_we_i(we),
        .bus_addr_i(addr), .rdata_o(rdata));
    task automatic summarize();
        $display("Checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic r, input logic w, input logic [15:0] ad, input logic [7:0] d);
        @(negedge clk);
        chk("bus_req", {15'h0, r}, {15'h0, req});
        if (r) begin
            chk("bus_we", {15'h0, w}, {15'h0, we});
            chk("bus_addr", ad, addr);
        end
        if (r && w) begin
            chk("bus_wdata", {8'h00, d}, {8'h00, wdata});
        end
    endtask
    task automatic idle(input int n);
        repeat (n) bus(1'b0, 1'b0, 16'h0, 8'h00);
    endtask
    task automatic fill(input logic [15:0] v);
        for (int k = 0; k < 3; k++) begin
            bus(1'b1, 1'b0, v + 16'(k), 8'h00);
        end
        chk("pc_load_valid", 16'h1, {15'h0, pvld});
        chk("pc_load", v, pload);
        @(negedge clk);
        chk("running", 16'h1, {15'h0, run});
    endtask
    task automatic reset_seq();
        int n;
        n = 0;
        while (n < 40) begin
            @(negedge clk);
            if (req === 1'b1) break;
            n++;
        end
        if (n >= 40) begin
            errors++;
            summarize();
        end
        chk("reset_hi", 16'hfffe, addr);
        bus(1'b1, 1'b0, 16'hffff, 8'h00);
        bus(1'b0, 1'b0, 16'h0, 8'h00);
        fill({u_mem.byte_at(16'hfffe), u_mem.byte_at(16'hffff)});
    endtask
    task automatic entry(input cpuex_row_t r);
        logic [7:0] st[5];
        st = '{pc[7:0], pc[15:8], x, a, cond_code};
        @(posedge clk);
        irq <= r.irq;
        trap <= r.trap;
        bnd <= !r.trap;
        @(posedge clk);
        // A later request must not retarget the vector already chosen
        irq <= 8'h80;
        trap <= 1'b0;
        bnd <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            bus(1'b1, 1'b1, sp - 16'(k), st[k]);
        end
        bus(1'b1, 1'b0, r.vec, 8'h00);
        chk("mask", 16'h1, {15'h0, mask});
        bus(1'b1, 1'b0, r.vec + 16'h1, 8'h00);
        bus(1'b0, 1'b0, 16'h0, 8'h00);
        fill({u_mem.byte_at(r.vec), u_mem.byte_at(r.vec + 16'h1)});
    endtask
    task automatic pg2(input logic [7:0] op, input logic [15:0] off, input logic [1:0] m,
        input logic [3:0] nb, input logic [3:0] nc);
        @(posedge clk);
        sp <= 16'h0100;
        opc <= 8'h9e;
        opv <= 1'b1;
        @(posedge clk);
        opc <= op;
        offs <= off;
        @(posedge clk);
        opv <= 1'b0;
        @(negedge clk);
        chk("page2", 16'h1, {15'h0, page2});
        chk("sp_mode", {14'h0, m}, {14'h0, mode});
        chk("sp_operand", 16'h0100 + off, spaddr);
        chk("instr_bytes", {12'h0, nb}, {12'h0, nbytes});
        chk("instr_cycles", {12'h0, nc}, {12'h0, ncyc});
    endtask
    initial begin
        #200000;
        errors++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        por = 1'b1;
        wdog = 1'b0;
        pin_n = 1'b0;
        chk_done = 1'b0;
        {bnd, trap, mclr, opv} = 4'h0;
        {irq, opc} = 16'h0;
        x = 8'h5a;
        a = 8'ha5;
        cond_code = 8'h01;
        pc = 16'h4000;
        sp = 16'h01ff;
        offs = 16'h0;
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        por <= 1'b0;
        chk_done <= 1'b1;
        idle(12);
        @(posedge clk);
        pin_n <= 1'b1;
        chk_done <= 1'b0;
        idle(12);
        @(posedge clk);
        chk_done <= 1'b1;
        reset_seq();
        chk("reset_mask", 16'h1, {15'h0, mask});
        foreach (rows[i]) begin
            @(posedge clk);
            pc <= 16'h4000 + 16'(i);
            sp <= 16'h01ff - 16'(i * 8);
            cond_code <= 8'(i);
            mclr <= !rows[i].trap;
            @(posedge clk);
            mclr <= 1'b0;
            entry(rows[i]);
        end
        // Masked request with a boundary must be ignored
        @(posedge clk);
        irq <= 8'h01;
        bnd <= 1'b1;
        @(posedge clk);
        bnd <= 1'b0;
        idle(6);
        @(posedge clk);
        mclr <= 1'b1;
        @(posedge clk);
        mclr <= 1'b0;
        idle(6);
        entry(rows[0]);
        pg2(8'h60, 16'h0085, 2'h1, 4'h3, 4'h6);
        pg2(8'hd6, 16'h1234, 2'h2, 4'h0, 4'h0);
        // Watchdog strikes in mid-stacking
        @(posedge clk);
        trap <= 1'b1;
        @(posedge clk);
        trap <= 1'b0;
        bus(1'b1, 1'b1, sp, pc[7:0]);
        bus(1'b1, 1'b1, sp - 16'h1, pc[15:8]);
        @(posedge clk);
        wdog <= 1'b1;
        bus(1'b1, 1'b1, sp - 16'h2, x);
        bus(1'b0, 1'b0, 16'h0, 8'h00);
        chk("abort_run", 16'h0, {15'h0, run});
        @(posedge clk);
        wdog <= 1'b0;
        reset_seq();
        // Pin pulled low while running aborts once it clears the synchroniser
        @(posedge clk);
        pin_n <= 1'b0;
        idle(4);
        chk("pin_abort", 16'h0, {15'h0, run});
        chk("pin_mask", 16'h1, {15'h0, mask});
        @(posedge clk);
        pin_n <= 1'b1;
        reset_seq();
        summarize();
    end
endmodule
